//--- design/pdc_pkg.sv
// Shared constants, field layout and carrier types of the configuration slave
package pdc_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int PDC_CLK_MHZ = 100;
  localparam int PDC_SCL_MAX_KHZ = 400;
  localparam int PDC_SPIKE_NS = 50;
  localparam int PDC_FILT_CYC = (PDC_SPIKE_NS * PDC_CLK_MHZ + 999) / 1000;
  localparam int PDC_FILT_W = 3;
  // ----------------------------------------------------------------
  // Serial addressing and configuration byte layout
  // ----------------------------------------------------------------
  localparam logic [3:0] PDC_ADDR_HI = 4'h5;
  localparam int PDC_CFG_BYTES = 14;
  localparam logic [7:0] PDC_IX_LAST = 8'h0d;
  localparam int PDC_IX_FLEXA = 5;
  localparam int PDC_IX_FLEXB = 7;
  localparam int PDC_IX_FLEXI = 9;
  localparam int PDC_IX_DIS = 11;
  localparam int PDC_IX_SHH = 12;
  localparam int PDC_IX_SHL = 13;
  typedef logic [PDC_CFG_BYTES-1:0][7:0] pdc_image_t;
  // Writable bits of each byte; the rest read as zero
  localparam pdc_image_t PDC_BYTE_MASK = {8'h1f, 8'h1f, 8'hff, 8'h03, 8'hff, 8'h03, 8'hff,
                                          8'h03, 8'hff, 8'h3f, 8'h3f, 8'h3f, 8'h3f, 8'h0f};
  // Factory image: 5/9/12/15 V at 3 A, 20 V at 2.25 A
  localparam pdc_image_t PDC_FACTORY = {8'h0a, 8'h0a, 8'h35, 8'h00, 8'he1, 8'h01, 8'h90,
                                        8'h00, 8'hf0, 8'h34, 8'h17, 8'h27, 8'h07, 8'h07};
  // ----------------------------------------------------------------
  // Decode units: voltage in 50 mV, current in 10 mA
  // ----------------------------------------------------------------
  localparam logic [9:0] PDC_V5 = 10'h064;
  localparam logic [9:0] PDC_V9 = 10'h0b4;
  localparam logic [9:0] PDC_V15 = 10'h12c;
  localparam logic [9:0] PDC_I_BASE = 10'h07d;
  localparam logic [9:0] PDC_I_STEP = 10'h019;
  localparam logic [8:0] PDC_T_OBJ_STEP_MS = 9'h014;
  localparam logic [10:0] PDC_T_ZERO_STEP_MS = 11'h054;
  localparam logic [4:0] PDC_SHIFT_MIN = 5'h05;
  localparam logic [4:0] PDC_SHIFT_MAX = 5'h14;
  // ----------------------------------------------------------------
  // Register bus map and non-volatile store
  // ----------------------------------------------------------------
  localparam logic [7:0] PDC_A_KEY = 8'h00;
  localparam logic [7:0] PDC_A_CTRL = 8'h04;
  localparam logic [7:0] PDC_A_STAT = 8'h08;
  localparam logic [1:0] PDC_HTRANS_NONSEQ = 2'h2;
  localparam logic [3:0] PDC_NVM_MAX_WRITES = 4'h4;
  localparam logic [31:0] PDC_NVM_KEY = 32'h5a3c_96e1; // Arbitrary value
  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hready;
  } pdc_ahb_req_t;
  typedef struct packed {
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
  } pdc_ahb_rsp_t;
  typedef struct packed {
    logic [4:0][9:0] obj_voltage;
    logic [4:0][9:0] obj_current;
    logic [9:0] flexible_voltage_a;
    logic [9:0] flexible_voltage_b;
    logic [9:0] flexible_current;
    logic [8:0] object_change_discharge_time;
    logic [10:0] zero_volt_discharge_time;
    logic [4:0] shift_high;
    logic [4:0] shift_low;
  } pdc_cfg_t;
  typedef enum logic [8:0] {
    PDC_S_IDLE = 9'h001,
    PDC_S_ADDR = 9'h002,
    PDC_S_AACK = 9'h004,
    PDC_S_REG = 9'h008,
    PDC_S_RACK = 9'h010,
    PDC_S_WDATA = 9'h020,
    PDC_S_WACK = 9'h040,
    PDC_S_TX = 9'h080,
    PDC_S_MACK = 9'h100
  } pdc_state_t;
endpackage

//--- design/pdc_pin_filter.sv
// Two-flop synchroniser and spike filter for the serial pins
`timescale 1ns/1ps
module pdc_pin_filter (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Raw pins and filtered levels
  input wire logic [1:0] pin_raw,
  output logic [1:0] pin_clean
);
  import pdc_pkg::*;
  typedef struct packed {
    logic [1:0] s1;
    logic [1:0] s2;
    logic [1:0][PDC_FILT_W-1:0] cnt;
    logic [1:0] lvl;
  } pdc_flt_t;
  pdc_flt_t f_reg, f_next;

  // ----------------------------------------------------------------
  // Filter: a new level is taken only after it held a spike width
  // ----------------------------------------------------------------
  // Delay is about 70 ns, far inside the 1.3 us low time at top speed
  always_comb begin
    f_next = f_reg;
    f_next.s1 = pin_raw;
    f_next.s2 = f_reg.s1;
    for (int i = 0; i < 2; i++) begin
      if (f_reg.s2[i] == f_reg.lvl[i]) begin
        f_next.cnt[i] = '0;
      end else if (f_reg.cnt[i] == PDC_FILT_W'(PDC_FILT_CYC - 1)) begin
        f_next.lvl[i] = f_reg.s2[i];
        f_next.cnt[i] = '0;
      end else begin
        f_next.cnt[i] = f_reg.cnt[i] + PDC_FILT_W'(1);
      end
    end
  end

  // Idle bus level is high for both lines
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      f_reg <= '{s1: 2'h3, s2: 2'h3, cnt: '0, lvl: 2'h3};
    end else begin
      f_reg <= f_next;
    end
  end

  assign pin_clean = f_reg.lvl;
endmodule

//--- design/pdc_nvm.sv
// Password-gated, write-limited store of the startup configuration image
`timescale 1ns/1ps
module pdc_nvm (
  // Clock and power-on reset
  input wire logic hclk,
  input wire logic por_n,
  // Programming request
  input wire logic prog,
  input wire logic [31:0] key,
  input wire pdc_pkg::pdc_image_t image_in,
  // Stored image and state
  output pdc_pkg::pdc_image_t image,
  output logic [3:0] writes_left
);
  import pdc_pkg::*;
  typedef struct packed {
    pdc_image_t img;
    logic [3:0] left;
  } pdc_nvm_st_t;
  pdc_nvm_st_t n_reg, n_next;

  // ----------------------------------------------------------------
  // Programming: only with the right key and while writes remain
  // ----------------------------------------------------------------
  always_comb begin
    n_next = n_reg;
    if (prog && key == PDC_NVM_KEY && n_reg.left != 4'h0) begin
      n_next.img = image_in & PDC_BYTE_MASK;
      n_next.left = n_reg.left - 4'h1;
    end
  end

  // Only power-on reloads the store with the factory image; the hardware reset leaves it alone
  always_ff @(posedge hclk or negedge por_n) begin
    if (!por_n) begin
      n_reg <= '{img: PDC_FACTORY, left: PDC_NVM_MAX_WRITES};
    end else begin
      n_reg <= n_next;
    end
  end

  assign image = n_reg.img;
  assign writes_left = n_reg.left;

  default clocking @(posedge hclk); endclocking
  default disable iff (!por_n);
  chk_nvm_key_gate: assert property (
    (prog && (key != PDC_NVM_KEY || n_reg.left == 4'h0)) |=> $stable(n_reg)
  ) else $error("store changed without valid key or remaining writes");
endmodule

//--- design/pdc_cfg_slave.sv
// Startup configuration registers behind a serial slave port, with bus access
//
// Function
// - On power-up and each reset, copy stored defaults into the configuration bytes.
// - Written values persist until overwritten; reset restores stored defaults.
// - Store reprogramming needs the password and is limited in count.
// - Object one fixed at 5 V; factory defaults 5/9/12/15 V 3 A, 20 V 2.25 A.
// - Voltage selector: 00 9 V, 01 15 V, 10 flexible A, 11 flexible B.
// - Each flexible voltage is a 10-bit value in 50 mV steps.
// - Current selector 0 picks flexible current, 1..15 give 1.50 to 5.00 A.
// - Flexible current is a 10-bit value in 10 mA steps.
// - Object change discharge time 20 to 300 ms in 20 ms steps.
// - Zero volt discharge time 84 to 1260 ms in 84 ms steps.
// - Upper and lower shift margins each 5 to 20 percent.
// - Slave only; every byte moves most significant bit first.
// - Serial clock from zero to 400 kHz; master keeps within it.
// - Spike filter on the serial data input before sampling.
// - Seven-bit address plus direction after start; answer only own address.
// - Own address is 0101 plus three strap bits.
// - Read: write register address, repeated start, then read data.
// - Discharge times default from store and are writable at run time.
//
// Added by the designer: the address map and the AHB-Lite register port.
`timescale 1ns/1ps
module pdc_cfg_slave (
  // Clock and resets
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic por_n,
  // Register bus
  input wire pdc_pkg::pdc_ahb_req_t ahb_req,
  output pdc_pkg::pdc_ahb_rsp_t ahb_rsp,
  // Serial pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Address straps
  input wire logic slave_addr_strap0,
  input wire logic slave_addr_strap1,
  input wire logic slave_addr_strap2,
  // Decoded configuration
  output pdc_pkg::pdc_cfg_t cfg
);
  import pdc_pkg::*;

  typedef struct packed {
    pdc_state_t st;
    logic loading;
    logic [2:0] strap;
    logic scl_d;
    logic sda_d;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic [7:0] idx;
    logic rw;
    logic sda_oe;
    pdc_image_t bytes;
    logic dph;
    logic dwr;
    logic [7:0] daddr;
    logic [31:0] key;
    logic prog;
    pdc_ahb_rsp_t rsp;
    pdc_cfg_t cfg;
  } pdc_st_t;
  pdc_st_t r_reg, r_next;

  logic [1:0] pins;
  pdc_image_t nvm_image;
  logic [3:0] nvm_left;
  logic scl_rise, scl_fall, start_c, stop_c, sda_c;
  logic [6:0] own_addr;

  // ----------------------------------------------------------------
  // Pin conditioning and store
  // ----------------------------------------------------------------
  pdc_pin_filter u_filter (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin_raw({scl_in, sda_in}),
    .pin_clean(pins)
  );

  pdc_nvm u_nvm (
    .hclk(hclk),
    .por_n(por_n),
    .prog(r_reg.prog),
    .key(r_reg.key),
    .image_in(r_reg.bytes),
    .image(nvm_image),
    .writes_left(nvm_left)
  );

  // Bus conditions seen on the filtered lines
  assign sda_c = pins[0];
  assign scl_rise = pins[1] && !r_reg.scl_d;
  assign scl_fall = !pins[1] && r_reg.scl_d;
  assign start_c = pins[1] && r_reg.scl_d && r_reg.sda_d && !sda_c;
  assign stop_c = pins[1] && r_reg.scl_d && !r_reg.sda_d && sda_c;
  assign own_addr = {PDC_ADDR_HI, r_reg.strap};

  // ----------------------------------------------------------------
  // Next state: serial engine, bus slave and decode
  // ----------------------------------------------------------------
  always_comb begin
    r_next = r_reg;
    r_next.scl_d = pins[1];
    r_next.sda_d = sda_c;
    r_next.prog = 1'b0;
    // Straps are caught after reset release, never by the reset itself
    if (r_reg.loading) begin
      r_next.loading = 1'b0;
      r_next.strap = {slave_addr_strap2, slave_addr_strap1, slave_addr_strap0};
      r_next.bytes = nvm_image;
    end else if (start_c) begin
      // A repeated start keeps the register index for the read
      r_next.st = PDC_S_ADDR;
      r_next.bitcnt = 4'h0;
      r_next.sda_oe = 1'b0;
    end else if (stop_c) begin
      r_next.st = PDC_S_IDLE;
      r_next.sda_oe = 1'b0;
    end else if (scl_rise) begin
      unique case (r_reg.st)
        PDC_S_ADDR, PDC_S_REG, PDC_S_WDATA: begin
          r_next.shreg = {r_reg.shreg[6:0], sda_c};
          r_next.bitcnt = r_reg.bitcnt + 4'h1;
        end
        PDC_S_MACK: begin
          // Master nack ends the read; ack asks for the next byte
          if (sda_c) begin
            r_next.st = PDC_S_IDLE;
          end
        end
        default: begin
        end
      endcase
    end else if (scl_fall) begin
      unique case (r_reg.st)
        PDC_S_ADDR: begin
          if (r_reg.bitcnt == 4'h8) begin
            if (r_reg.shreg[7:1] == own_addr) begin
              r_next.st = PDC_S_AACK;
              r_next.rw = r_reg.shreg[0];
              r_next.sda_oe = 1'b1;
            end else begin
              r_next.st = PDC_S_IDLE;
            end
          end
        end
        PDC_S_AACK, PDC_S_RACK, PDC_S_WACK, PDC_S_MACK: begin
          r_next.bitcnt = 4'h0;
          r_next.sda_oe = 1'b0;
          if ((r_reg.st == PDC_S_AACK && r_reg.rw) || r_reg.st == PDC_S_MACK) begin
            r_next.st = PDC_S_TX;
            if (r_reg.idx <= PDC_IX_LAST) begin
              r_next.shreg = r_reg.bytes[r_reg.idx[3:0]];
            end else begin
              r_next.shreg = 8'h00;
            end
            r_next.sda_oe = !r_next.shreg[7];
            r_next.idx = r_reg.idx + 8'h01;
          end else if (r_reg.st == PDC_S_AACK) begin
            r_next.st = PDC_S_REG;
          end else begin
            r_next.st = PDC_S_WDATA;
          end
        end
        PDC_S_REG: begin
          if (r_reg.bitcnt == 4'h8) begin
            r_next.idx = r_reg.shreg;
            r_next.st = PDC_S_RACK;
            r_next.sda_oe = 1'b1;
          end
        end
        PDC_S_WDATA: begin
          if (r_reg.bitcnt == 4'h8) begin
            if (r_reg.idx <= PDC_IX_LAST) begin
              r_next.bytes[r_reg.idx[3:0]] = r_reg.shreg & PDC_BYTE_MASK[r_reg.idx[3:0]];
              // Margins outside 5..20 percent are pulled into range
              if (r_reg.idx == 8'(PDC_IX_SHH) || r_reg.idx == 8'(PDC_IX_SHL)) begin
                if (r_reg.shreg[4:0] < PDC_SHIFT_MIN || r_reg.shreg[7:5] != 3'h0) begin
                  r_next.bytes[r_reg.idx[3:0]] = {3'h0, r_reg.shreg[7:5] != 3'h0 ?
                                                  PDC_SHIFT_MAX : PDC_SHIFT_MIN};
                end else if (r_reg.shreg[4:0] > PDC_SHIFT_MAX) begin
                  r_next.bytes[r_reg.idx[3:0]] = {3'h0, PDC_SHIFT_MAX};
                end
              end
            end
            r_next.idx = r_reg.idx + 8'h01;
            r_next.st = PDC_S_WACK;
            r_next.sda_oe = 1'b1;
          end
        end
        PDC_S_TX: begin
          r_next.bitcnt = r_reg.bitcnt + 4'h1;
          if (r_reg.bitcnt == 4'h7) begin
            r_next.st = PDC_S_MACK;
            r_next.sda_oe = 1'b0;
          end else begin
            r_next.shreg = {r_reg.shreg[6:0], 1'b0};
            r_next.sda_oe = !r_reg.shreg[6];
          end
        end
        default: begin
        end
      endcase
    end

    // Bus slave: one wait state, data stands with the ready pulse
    r_next.rsp.hresp = 1'b0;
    r_next.rsp.hreadyout = 1'b1;
    r_next.dph = 1'b0;
    if (ahb_req.hsel && ahb_req.hready && ahb_req.htrans == PDC_HTRANS_NONSEQ) begin
      r_next.dph = 1'b1;
      r_next.dwr = ahb_req.hwrite;
      r_next.daddr = ahb_req.haddr[7:0];
      r_next.rsp.hreadyout = 1'b0;
    end
    if (r_reg.dph) begin
      r_next.rsp.hrdata = 32'h0000_0000;
      if (r_reg.dwr) begin
        if (r_reg.daddr == PDC_A_KEY) begin
          r_next.key = ahb_req.hwdata;
        end
        r_next.prog = r_reg.daddr == PDC_A_CTRL && ahb_req.hwdata[0];
      end else if (r_reg.daddr == PDC_A_STAT) begin
        r_next.rsp.hrdata = {16'h0000, 4'h0, nvm_left, 1'b0, own_addr};
      end else if (r_reg.daddr == PDC_A_CTRL) begin
        r_next.rsp.hrdata = {23'h000000, r_reg.st};
      end
    end

    // Decoded values, registered so the outputs come straight from flops
    r_next.cfg.flexible_voltage_a = {r_reg.bytes[PDC_IX_FLEXA+1][1:0],
                                     r_reg.bytes[PDC_IX_FLEXA]};
    r_next.cfg.flexible_voltage_b = {r_reg.bytes[PDC_IX_FLEXB+1][1:0],
                                     r_reg.bytes[PDC_IX_FLEXB]};
    r_next.cfg.flexible_current = {r_reg.bytes[PDC_IX_FLEXI+1][1:0],
                                   r_reg.bytes[PDC_IX_FLEXI]};
    for (int k = 0; k < 5; k++) begin
      // Voltage selector lives in bits 5:4, current selector in 3:0
      unique case (r_reg.bytes[k][5:4])
        2'h0: r_next.cfg.obj_voltage[k] = PDC_V9;
        2'h1: r_next.cfg.obj_voltage[k] = PDC_V15;
        2'h2: r_next.cfg.obj_voltage[k] = r_next.cfg.flexible_voltage_a;
        2'h3: r_next.cfg.obj_voltage[k] = r_next.cfg.flexible_voltage_b;
      endcase
      if (r_reg.bytes[k][3:0] == 4'h0) begin
        r_next.cfg.obj_current[k] = r_next.cfg.flexible_current;
      end else begin
        r_next.cfg.obj_current[k] = PDC_I_BASE + PDC_I_STEP * {6'h00, r_reg.bytes[k][3:0]};
      end
    end
    r_next.cfg.obj_voltage[0] = PDC_V5;
    r_next.cfg.object_change_discharge_time =
      PDC_T_OBJ_STEP_MS * {5'h00, r_reg.bytes[PDC_IX_DIS][3:0]};
    r_next.cfg.zero_volt_discharge_time =
      PDC_T_ZERO_STEP_MS * {7'h00, r_reg.bytes[PDC_IX_DIS][7:4]};
    r_next.cfg.shift_high = r_reg.bytes[PDC_IX_SHH][4:0];
    r_next.cfg.shift_low = r_reg.bytes[PDC_IX_SHL][4:0];
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Reset holds factory values; the stored image replaces them next cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r_reg <= '{st: PDC_S_IDLE, loading: 1'b1, strap: 3'h0, scl_d: 1'b1, sda_d: 1'b1,
                 bitcnt: 4'h0, shreg: 8'h00, idx: 8'h00, rw: 1'b0, sda_oe: 1'b0,
                 bytes: PDC_FACTORY, dph: 1'b0, dwr: 1'b0, daddr: 8'h00, key: 32'h0,
                 prog: 1'b0, rsp: '{hrdata: 32'h0, hreadyout: 1'b1, hresp: 1'b0},
                 cfg: '0};
    end else begin
      r_reg <= r_next;
    end
  end

  assign ahb_rsp = r_reg.rsp;
  assign sda_out = 1'b0;
  assign sda_oe = r_reg.sda_oe;
  assign cfg = r_reg.cfg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  chk_load_defaults: assert property (
    $fell(r_reg.loading) |-> r_reg.bytes == nvm_image
  ) else $error("configuration not loaded from store after reset");
  chk_obj1_fixed: assert property (
    !r_reg.loading |=> cfg.obj_voltage[0] == PDC_V5
  ) else $error("object one voltage not 5 V");
  chk_volt_decode: assert property (
    r_reg.bytes[1][5:4] == 2'h1 ##1 r_reg.bytes[1][5:4] == 2'h1 |-> cfg.obj_voltage[1] == PDC_V15
  ) else $error("voltage selector 01 not decoded as 15 V");
  chk_cur_decode: assert property (
    r_reg.bytes[2][3:0] == 4'hf ##1 r_reg.bytes[2][3:0] == 4'hf |-> cfg.obj_current[2] == 10'h1f4
  ) else $error("current selector 1111 not decoded as 5 A");
  chk_shift_range: assert property (
    !r_reg.loading |-> r_reg.bytes[PDC_IX_SHH][4:0] inside {[PDC_SHIFT_MIN:PDC_SHIFT_MAX]}
  ) else $error("upper shift margin out of range");
  chk_addr_ack: assert property (
    $rose(r_reg.st == PDC_S_AACK) |-> r_reg.sda_oe && $past(r_reg.shreg[7:1]) == own_addr
  ) else $error("acknowledged a foreign address");
  chk_tx_msb_first: assert property (
    (r_reg.st == PDC_S_TX && scl_fall && r_reg.bitcnt != 4'h7)
      |=> r_reg.sda_oe == !$past(r_reg.shreg[6])
  ) else $error("transmit bit order wrong");
  chk_idx_step: assert property (
    (r_reg.st == PDC_S_WDATA && r_next.st == PDC_S_WACK) |=> r_reg.idx == $past(r_reg.idx) + 8'h01
  ) else $error("register index did not advance after data byte");
  chk_bus_wait: assert property (
    (ahb_req.hsel && ahb_req.hready && ahb_req.htrans == PDC_HTRANS_NONSEQ)
      |=> !ahb_rsp.hreadyout ##1 ahb_rsp.hreadyout
  ) else $error("bus answer not after exactly one wait state");
endmodule

//--- testbench/pdc_i2c_master.sv
// Serial bus master model that drives the clock and pulls the data line low
`timescale 1ns/1ps
module pdc_i2c_master #(
  parameter int Q = 65
) (
  // Clock and bus lines
  input wire logic hclk,
  input wire logic sda,
  output logic scl,
  output logic m_oe
);
  // ----------
  // Bus phases
  // ----------
  // Clock idles high; it only toggles inside frames
  initial begin
    scl = 1'b1;
    m_oe = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
  endtask
  // Quarter bit of Q clocks keeps low time at 1.3 us, under 400 kHz
  task automatic bit_io(input logic b, output logic s);
    m_oe <= !b;
    tick(Q);
    scl <= 1'b1;
    tick(Q);
    s = sda;
    tick(Q);
    scl <= 1'b0;
    tick(Q);
  endtask
  // Start or repeated start: data falls while the clock is high
  task automatic start();
    m_oe <= 1'b0;
    tick(Q);
    scl <= 1'b1;
    tick(Q);
    m_oe <= 1'b1;
    tick(Q);
    scl <= 1'b0;
    tick(Q);
  endtask
  // Stop, then bus free time before the next start
  task automatic stop();
    m_oe <= 1'b1;
    tick(Q);
    scl <= 1'b1;
    tick(Q);
    m_oe <= 1'b0;
    tick(2 * Q);
  endtask
  // Byte out, MSB first, then the slave's ack bit
  task automatic put(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s);
    ack = !s;
  endtask
  // Byte in; ack to go on, nack on the last one
  task automatic get(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      d[i] = s;
    end
    bit_io(last, s);
  endtask
endmodule

//--- testbench/testbench.sv
// Self-checking bench for the configuration slave
`timescale 1ns/1ps
module testbench;
  import pdc_pkg::*;
  localparam logic [6:0] DEV = 7'h2a;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic por_n = 1'b0;
  logic sda_out, sda_oe, scl, m_oe;
  wire logic sda = !(sda_oe | m_oe);
  pdc_ahb_req_t rq = '0;
  pdc_ahb_req_t req;
  pdc_ahb_rsp_t rsp;
  pdc_cfg_t cfg;
  int fails = 0;
  int n_tests = 0;
  always #5 hclk = !hclk;
  // Single slave, so its ready is the bus ready
  always_comb begin
    req = rq;
    req.hready = rsp.hreadyout;
  end
  pdc_cfg_slave u_pdc_cfg_slave (.hclk(hclk), .hresetn(hresetn), .por_n(por_n),
    .ahb_req(req), .ahb_rsp(rsp), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .slave_addr_strap0(1'b0), .slave_addr_strap1(1'b1),
    .slave_addr_strap2(1'b0), .cfg(cfg));
  pdc_i2c_master u_mst (.hclk(hclk), .sda(sda), .scl(scl), .m_oe(m_oe));
  // ----------
  // Helpers
  // ----------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("Checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Power-on reset also returns the store to its factory image
  task automatic do_reset(input logic pwr);
    hresetn <= 1'b0;
    por_n <= !pwr;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    por_n <= 1'b1;
    repeat (4) @(posedge hclk);
  endtask
  // One single transfer; entered just after a rising edge
  task automatic ahb(input logic w, input logic [31:0] a, d, output logic [31:0] r);
    rq.hsel <= 1'b1;
    rq.htrans <= PDC_HTRANS_NONSEQ;
    rq.haddr <= a;
    rq.hwrite <= w;
    rq.hsize <= 3'h2;
    do @(posedge hclk); while (rsp.hreadyout !== 1'b1);
    rq.htrans <= 2'h0;
    rq.hwdata <= d;
    do @(posedge hclk); while (rsp.hreadyout !== 1'b1);
    r = rsp.hrdata;
  endtask
  task automatic wr(input logic [7:0] ix, input logic [7:0] q[$]);
    logic a;
    u_mst.start();
    u_mst.put({DEV, 1'b0}, a);
    chk(a, 1);
    u_mst.put(ix, a);
    chk(a, 1);
    foreach (q[i]) begin
      u_mst.put(q[i], a);
      chk(a, 1);
    end
    u_mst.stop();
    repeat (5) @(posedge hclk);
  endtask
  // ----------
  // Scenarios
  // ----------
  task automatic t_defaults();
    int v[5] = '{100, 180, 240, 300, 400};
    for (int k = 0; k < 5; k++) begin
      chk(cfg.obj_voltage[k], v[k]);
      chk(cfg.obj_current[k], k < 4 ? 300 : 225);
    end
    chk(cfg.flexible_current, 225);
    chk(cfg.flexible_voltage_b, 400);
    chk(sda_out, 0);
    chk(cfg.shift_high, 10);
  endtask
  // Every selector code kind, plus a flexible voltage in one burst
  task automatic t_write();
    int v[4] = '{300, 290, 400, 180};
    int c[4] = '{225, 500, 150, 225};
    wr(8'h01, '{8'h10, 8'h2f, 8'h31, 8'h00, 8'h22, 8'h01});
    for (int k = 1; k < 5; k++) begin
      chk(cfg.obj_voltage[k], v[k-1]);
      chk(cfg.obj_current[k], c[k-1]);
    end
    chk(cfg.flexible_voltage_a, 290);
  endtask
  task automatic t_read();
    logic a;
    logic [7:0] d;
    u_mst.start();
    u_mst.put({DEV, 1'b0}, a);
    u_mst.put(8'h02, a);
    u_mst.start();
    u_mst.put({DEV, 1'b1}, a);
    chk(a, 1);
    u_mst.get(1'b0, d);
    chk(d, 8'h2f);
    u_mst.get(1'b1, d);
    chk(d, 8'h31);
    u_mst.stop();
  endtask
  // Wrong strap bits, then wrong fixed upper bits: no answer
  task automatic t_foreign();
    logic a;
    logic [6:0] f[2] = '{7'h2b, 7'h6a};
    foreach (f[i]) begin
      u_mst.start();
      u_mst.put({f[i], 1'b0}, a);
      chk(a, 0);
      u_mst.stop();
    end
  endtask
  task automatic t_timing();
    wr(8'h0b, '{8'hff, 8'h14, 8'h05});
    chk(cfg.zero_volt_discharge_time, 1260);
    chk(cfg.object_change_discharge_time, 300);
    chk(cfg.shift_low, 5);
  endtask
  task automatic t_store();
    logic [31:0] r;
    ahb(1'b0, 32'h8, 0, r);
    chk(r[11:0], {4'h4, 1'b0, DEV});
    ahb(1'b1, 32'h4, 1, r);
    ahb(1'b0, 32'h8, 0, r);
    chk(r[11:8], 4);
    ahb(1'b0, 32'h40, 0, r);
    chk(r, 0);
    do_reset(1'b0);
    t_defaults();
    wr(8'h0c, '{8'h14});
    ahb(1'b1, 32'h0, PDC_NVM_KEY, r);
    ahb(1'b1, 32'h4, 1, r);
    ahb(1'b0, 32'h8, 0, r);
    chk(r[11:8], 3);
    do_reset(1'b0);
    chk(cfg.shift_high, 20);
    do_reset(1'b1);
    t_defaults();
  endtask
  initial begin
    do_reset(1'b1);
    t_defaults();
    t_write();
    t_read();
    t_foreign();
    t_timing();
    t_store();
    stop_test();
  end
  // Whole run needs about 0.6 ms; the limit stays under 100k clocks
  initial begin
    #900000;
    fails++;
    $display("BAD %0t watchdog expired", $time);
    stop_test();
  end
endmodule
